// File: include/meter_cfg_pkg.sv
// Package: register map, field layout, reset values and timing for the metering configuration bank
package meter_cfg_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_LINE_MEAS = 8'h0A;
  localparam logic [7:0] IDX_GENERAL_MODE = 8'h0B;
  localparam logic [7:0] IDX_PULSE_OUTPUT_MODE = 8'h0C;
  localparam logic [7:0] IDX_WAVEFORM_SELECT = 8'h0D;
  localparam logic [7:0] IDX_NO_LOAD_THRESHOLD = 8'h0E;
  localparam int ADDR_W = 8;

  // Reset values
  localparam logic [7:0] GENERAL_MODE_RST = 8'h06;
  localparam logic [7:0] PULSE_OUTPUT_MODE_RST = 8'h41;
  localparam logic [7:0] WAVEFORM_SELECT_RST = 8'h00;
  localparam logic [7:0] NO_LOAD_THRESHOLD_RST = 8'h00;

  // General mode fields
  localparam int GM_SOFT_RESET = 7;
  localparam int GM_ZX_LPF_BYPASS = 6;
  localparam int GM_INTEGRATOR = 5;
  localparam int GM_SWAP = 4;
  localparam int GM_POWER_DOWN = 3;
  localparam int GM_PULSE_TWO_DIS = 2;
  localparam int GM_PULSE_ONE_DIS = 1;
  localparam int GM_HPF_BYPASS = 0;

  // Pulse output mode fields
  localparam int PM_TWO_SRC_LSB = 6;
  localparam int PM_ONE_SRC_LSB = 4;
  localparam int PM_APPARENT_RMS = 3;
  localparam int PM_ZX_RMS = 2;
  localparam int PM_FREQ_SEL = 1;
  localparam int PM_RESERVED_ONE = 0;

  // Waveform fields
  localparam int WV_TWO_SRC_LSB = 5;
  localparam int WV_ONE_SRC_LSB = 2;
  localparam int WV_RATE_LSB = 0;

  // No-load fields
  localparam int NL_IRMS_EN = 6;
  localparam int NL_APPARENT_LSB = 4;
  localparam int NL_REACTIVE_LSB = 2;
  localparam int NL_ACTIVE_LSB = 0;

  // Sample timing: base rate is pclk-derived tick at 819.2 kHz nominal
  localparam int PCLK_HZ = 20000000;
  localparam int BASE_HZ = 819200;
  localparam int BASE_DIV = (PCLK_HZ + BASE_HZ - 1) / BASE_HZ;
  localparam logic [7:0] BASE_DIV_M1 = 8'(BASE_DIV - 1);
  localparam logic [7:0] RATE_DIV_32_M1 = 8'h1F;

  // Pulse source selections
  typedef enum logic [1:0] {
    SRC_ACTIVE = 2'h0,
    SRC_REACTIVE = 2'h1,
    SRC_APPARENT = 2'h2,
    SRC_IRMS = 2'h3
  } pulse_src_t;

  // Waveform source codes
  localparam logic [2:0] WAV_CURRENT = 3'h0;
  localparam logic [2:0] WAV_VOLTAGE = 3'h1;
  localparam logic [2:0] WAV_ACTIVE = 3'h2;
  localparam logic [2:0] WAV_REACTIVE = 3'h3;
  localparam logic [2:0] WAV_APPARENT = 3'h4;
  localparam logic [2:0] WAV_IRMS = 3'h5;

  // No-load threshold codes in units of 0.0001% of full scale (ppm), 0 means disabled
  localparam logic [15:0] NL_APP_LEVEL1 = 16'h012C;
  localparam logic [15:0] NL_APP_LEVEL2 = 16'h0096;
  localparam logic [15:0] NL_APP_LEVEL3 = 16'h004B;
  localparam logic [15:0] NL_RA_LEVEL1 = 16'h0096;
  localparam logic [15:0] NL_RA_LEVEL2 = 16'h004B;
  localparam logic [15:0] NL_RA_LEVEL3 = 16'h0025;

  // Controls to the metering datapath
  typedef struct packed {
    logic soft_reset_pulse;
    logic zero_cross_filter_bypass;
    logic integrator_enable;
    logic channel_swap;
    logic converter_power_down;
    logic pulse_two_disable;
    logic pulse_one_disable;
    logic highpass_bypass;
    pulse_src_t pulse_two_source;
    pulse_src_t pulse_one_source;
    logic rms_zero_cross_update;
    logic period_frequency_select;
    logic current_rms_noload_enable;
    logic [15:0] apparent_noload_level;
    logic [15:0] reactive_noload_level;
    logic [15:0] active_noload_level;
  } meter_ctrl_t;

  // Raw samples from the datapath: 24-bit waveforms, 32-bit filtered current RMS, 16-bit line period and frequency
  typedef struct packed {
    logic [23:0] current;
    logic [23:0] voltage;
    logic [23:0] active;
    logic [23:0] reactive;
    logic [23:0] apparent;
    logic [31:0] irms_lpf;
    logic [15:0] line_period;
    logic [15:0] line_frequency;
  } meter_samples_t;

endpackage

// File: src/energy_meter_config_regs.sv
// Configuration register bank for the metering core with APB slave and waveform sampler
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module energy_meter_config_regs (
  input wire logic pclk,                                 // APB clock, 20 MHz
  input wire logic presetn,                              // Asynchronous reset, active low
  input wire logic psel,                                 // APB select
  input wire logic penable,                              // APB enable
  input wire logic pwrite,                               // APB direction, high for write
  input wire logic [31:0] paddr,                         // APB byte address
  input wire logic [31:0] pwdata,                        // APB write data
  input wire logic [3:0] pstrb,                          // APB byte strobes
  output logic [31:0] prdata,                            // APB read data
  output logic pready,                                   // APB ready
  output logic pslverr,                                  // APB error for unmapped address
  input wire meter_cfg_pkg::meter_samples_t samples,     // Datapath samples, same clock
  output meter_cfg_pkg::meter_ctrl_t ctrl,               // Controls to the datapath
  output logic [23:0] waveform_one,                      // Waveform one sample
  output logic [23:0] waveform_two,                      // Waveform two sample
  output logic waveform_valid                            // One-cycle pulse when samples update
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [7:0] general_mode_reg;
  logic [7:0] general_mode_next;
  logic [7:0] pulse_output_mode_reg;
  logic [7:0] pulse_output_mode_next;
  logic [7:0] waveform_select_reg;
  logic [7:0] waveform_select_next;
  logic [7:0] no_load_threshold_reg;
  logic [7:0] no_load_threshold_next;
  logic soft_reset_reg;
  logic soft_reset_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic pslverr_next;

  logic setup_phase;
  logic access_done;
  logic wr_en;
  logic mapped;
  logic word_aligned;
  logic [meter_cfg_pkg::ADDR_W-1:0] idx;

  assign pready = 1'b1;
  assign setup_phase = psel && !penable;
  assign access_done = psel && penable;
  assign word_aligned = (paddr[1:0] == 2'h0) && (paddr[31:10] == 22'h000000);
  assign idx = paddr[9:2];
  assign mapped = word_aligned && (idx >= meter_cfg_pkg::IDX_LINE_MEAS) &&
                  (idx <= meter_cfg_pkg::IDX_NO_LOAD_THRESHOLD);
  assign wr_en = access_done && pwrite && mapped && pstrb[0];
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg && access_done;

  ////////////////////////////////////////////////////////////////////////////
  // Register write and read path

  always_comb begin
    general_mode_next = general_mode_reg;
    pulse_output_mode_next = pulse_output_mode_reg;
    waveform_select_next = waveform_select_reg;
    no_load_threshold_next = no_load_threshold_reg;
    soft_reset_next = 1'b0;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (setup_phase) begin
      pslverr_next = !mapped;
      prdata_next = 32'h00000000;
      if (!pwrite && mapped) begin
        case (idx)
          meter_cfg_pkg::IDX_LINE_MEAS: begin
            prdata_next = {16'h0000, samples.line_frequency};
            if (!pulse_output_mode_reg[meter_cfg_pkg::PM_FREQ_SEL]) begin
              prdata_next = {16'h0000, samples.line_period};
            end
          end
          meter_cfg_pkg::IDX_GENERAL_MODE: begin
            prdata_next = {24'h000000, general_mode_reg};
          end
          meter_cfg_pkg::IDX_PULSE_OUTPUT_MODE: begin
            prdata_next = {24'h000000, pulse_output_mode_reg};
          end
          meter_cfg_pkg::IDX_WAVEFORM_SELECT: begin
            prdata_next = {24'h000000, waveform_select_reg};
          end
          meter_cfg_pkg::IDX_NO_LOAD_THRESHOLD: begin
            prdata_next = {24'h000000, no_load_threshold_reg};
          end
          default: begin
            prdata_next = 32'h00000000;
          end
        endcase
      end
    end
    if (wr_en) begin
      case (idx)
        meter_cfg_pkg::IDX_GENERAL_MODE: begin
          if (pwdata[meter_cfg_pkg::GM_SOFT_RESET]) begin
            // Soft reset self-clears: every bank register goes back to default
            general_mode_next = meter_cfg_pkg::GENERAL_MODE_RST;
            pulse_output_mode_next = meter_cfg_pkg::PULSE_OUTPUT_MODE_RST;
            waveform_select_next = meter_cfg_pkg::WAVEFORM_SELECT_RST;
            no_load_threshold_next = meter_cfg_pkg::NO_LOAD_THRESHOLD_RST;
            soft_reset_next = 1'b1;
          end else begin
            general_mode_next = pwdata[7:0];
          end
        end
        meter_cfg_pkg::IDX_PULSE_OUTPUT_MODE: begin
          pulse_output_mode_next = pwdata[7:0];
        end
        meter_cfg_pkg::IDX_WAVEFORM_SELECT: begin
          waveform_select_next = pwdata[7:0];
        end
        meter_cfg_pkg::IDX_NO_LOAD_THRESHOLD: begin
          // Top bit is reserved and reads zero
          no_load_threshold_next = {1'b0, pwdata[6:0]};
        end
        default: begin
          general_mode_next = general_mode_reg;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_mode_reg <= meter_cfg_pkg::GENERAL_MODE_RST;
      pulse_output_mode_reg <= meter_cfg_pkg::PULSE_OUTPUT_MODE_RST;
      waveform_select_reg <= meter_cfg_pkg::WAVEFORM_SELECT_RST;
      no_load_threshold_reg <= meter_cfg_pkg::NO_LOAD_THRESHOLD_RST;
      soft_reset_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      general_mode_reg <= general_mode_next;
      pulse_output_mode_reg <= pulse_output_mode_next;
      waveform_select_reg <= waveform_select_next;
      no_load_threshold_reg <= no_load_threshold_next;
      soft_reset_reg <= soft_reset_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Datapath controls

  function automatic meter_cfg_pkg::pulse_src_t pulse_src(input logic [1:0] code, input logic rms_sel);
    meter_cfg_pkg::pulse_src_t src;
    src = meter_cfg_pkg::SRC_ACTIVE;
    case (code)
      2'h0: src = meter_cfg_pkg::SRC_ACTIVE;
      2'h1: src = meter_cfg_pkg::SRC_REACTIVE;
      default: src = rms_sel ? meter_cfg_pkg::SRC_IRMS : meter_cfg_pkg::SRC_APPARENT;
    endcase
    return src;
  endfunction

  function automatic logic [15:0] nl_level(input logic [1:0] code, input logic apparent);
    logic [15:0] lvl;
    lvl = 16'h0000;
    case (code)
      2'h1: lvl = apparent ? meter_cfg_pkg::NL_APP_LEVEL1 : meter_cfg_pkg::NL_RA_LEVEL1;
      2'h2: lvl = apparent ? meter_cfg_pkg::NL_APP_LEVEL2 : meter_cfg_pkg::NL_RA_LEVEL2;
      2'h3: lvl = apparent ? meter_cfg_pkg::NL_APP_LEVEL3 : meter_cfg_pkg::NL_RA_LEVEL3;
      default: lvl = 16'h0000;
    endcase
    return lvl;
  endfunction

  always_comb begin
    ctrl.soft_reset_pulse = soft_reset_reg;
    ctrl.zero_cross_filter_bypass = general_mode_reg[meter_cfg_pkg::GM_ZX_LPF_BYPASS];
    ctrl.integrator_enable = general_mode_reg[meter_cfg_pkg::GM_INTEGRATOR];
    ctrl.channel_swap = general_mode_reg[meter_cfg_pkg::GM_SWAP];
    ctrl.converter_power_down = general_mode_reg[meter_cfg_pkg::GM_POWER_DOWN];
    ctrl.pulse_two_disable = general_mode_reg[meter_cfg_pkg::GM_PULSE_TWO_DIS];
    ctrl.pulse_one_disable = general_mode_reg[meter_cfg_pkg::GM_PULSE_ONE_DIS];
    ctrl.highpass_bypass = general_mode_reg[meter_cfg_pkg::GM_HPF_BYPASS];
    ctrl.pulse_two_source = pulse_src(pulse_output_mode_reg[meter_cfg_pkg::PM_TWO_SRC_LSB +: 2],
                                      pulse_output_mode_reg[meter_cfg_pkg::PM_APPARENT_RMS]);
    ctrl.pulse_one_source = pulse_src(pulse_output_mode_reg[meter_cfg_pkg::PM_ONE_SRC_LSB +: 2],
                                      pulse_output_mode_reg[meter_cfg_pkg::PM_APPARENT_RMS]);
    ctrl.rms_zero_cross_update = pulse_output_mode_reg[meter_cfg_pkg::PM_ZX_RMS];
    ctrl.period_frequency_select = pulse_output_mode_reg[meter_cfg_pkg::PM_FREQ_SEL];
    ctrl.current_rms_noload_enable = no_load_threshold_reg[meter_cfg_pkg::NL_IRMS_EN];
    ctrl.apparent_noload_level = nl_level(no_load_threshold_reg[meter_cfg_pkg::NL_APPARENT_LSB +: 2], 1'b1);
    ctrl.reactive_noload_level = nl_level(no_load_threshold_reg[meter_cfg_pkg::NL_REACTIVE_LSB +: 2], 1'b0);
    ctrl.active_noload_level = nl_level(no_load_threshold_reg[meter_cfg_pkg::NL_ACTIVE_LSB +: 2], 1'b0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform sample rate: base tick, then divide by 32 << rate code

  logic [7:0] base_cnt_reg;
  logic [7:0] base_cnt_next;
  logic [7:0] rate_cnt_reg;
  logic [7:0] rate_cnt_next;
  logic [7:0] rate_limit;
  logic base_tick;
  logic sample_tick;

  assign rate_limit = 8'((16'(meter_cfg_pkg::RATE_DIV_32_M1) << waveform_select_reg[1:0]) |
                         ((16'h0001 << waveform_select_reg[1:0]) - 16'h0001));
  assign base_tick = (base_cnt_reg == meter_cfg_pkg::BASE_DIV_M1);
  assign sample_tick = base_tick && (rate_cnt_reg >= rate_limit);

  always_comb begin
    base_cnt_next = base_tick ? 8'h00 : base_cnt_reg + 8'h01;
    rate_cnt_next = rate_cnt_reg;
    if (base_tick) begin
      rate_cnt_next = sample_tick ? 8'h00 : rate_cnt_reg + 8'h01;
    end
    if (soft_reset_reg) begin
      base_cnt_next = 8'h00;
      rate_cnt_next = 8'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_reg <= 8'h00;
      rate_cnt_reg <= 8'h00;
    end else begin
      base_cnt_reg <= base_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Waveform source selection

  function automatic logic [23:0] wav_pick(input logic [2:0] code, input meter_cfg_pkg::meter_samples_t s);
    logic [23:0] v;
    v = 24'h000000;
    case (code)
      meter_cfg_pkg::WAV_CURRENT: v = s.current;
      meter_cfg_pkg::WAV_VOLTAGE: v = s.voltage;
      meter_cfg_pkg::WAV_ACTIVE: v = s.active;
      meter_cfg_pkg::WAV_REACTIVE: v = s.reactive;
      meter_cfg_pkg::WAV_APPARENT: v = s.apparent;
      meter_cfg_pkg::WAV_IRMS: v = s.irms_lpf[23:0];
      default: v = 24'h000000;
    endcase
    return v;
  endfunction

  logic [23:0] wav_one_reg;
  logic [23:0] wav_one_next;
  logic [23:0] wav_two_reg;
  logic [23:0] wav_two_next;
  logic wav_valid_reg;
  logic wav_valid_next;

  always_comb begin
    wav_one_next = wav_one_reg;
    wav_two_next = wav_two_reg;
    wav_valid_next = sample_tick;
    if (sample_tick) begin
      wav_one_next = wav_pick(waveform_select_reg[meter_cfg_pkg::WV_ONE_SRC_LSB +: 3], samples);
      wav_two_next = wav_pick(waveform_select_reg[meter_cfg_pkg::WV_TWO_SRC_LSB +: 3], samples);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wav_one_reg <= 24'h000000;
      wav_two_reg <= 24'h000000;
      wav_valid_reg <= 1'b0;
    end else begin
      wav_one_reg <= wav_one_next;
      wav_two_reg <= wav_two_next;
      wav_valid_reg <= wav_valid_next;
    end
  end

  assign waveform_one = wav_one_reg;
  assign waveform_two = wav_two_reg;
  assign waveform_valid = wav_valid_reg;

endmodule

// File: testbench/energy_meter_config_props.sv
// Concurrent checks on the metering configuration bank ports
`timescale 1ns/1ps
module energy_meter_config_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [31:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [3:0] pstrb, // APB strobes
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire meter_cfg_pkg::meter_samples_t samples, // Datapath samples
  input wire meter_cfg_pkg::meter_ctrl_t ctrl, // Datapath controls
  input wire logic waveform_valid // Sample strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc_w;
  logic [6:0] gm_bits;
  assign acc_w = psel && penable && pwrite && pready && pstrb[0];
  assign gm_bits = {ctrl.zero_cross_filter_bypass, ctrl.integrator_enable, ctrl.channel_swap,
    ctrl.converter_power_down, ctrl.pulse_two_disable, ctrl.pulse_one_disable, ctrl.highpass_bypass};
  soft_reset_a: assert property (
    acc_w && paddr == 32'h2C && pwdata[7] |=> ctrl.soft_reset_pulse && gm_bits == 7'h06
    && ctrl.pulse_two_source == meter_cfg_pkg::SRC_REACTIVE) else $error("Soft reset did not restore defaults");
  pulse_once_a: assert property (
    ctrl.soft_reset_pulse |=> !ctrl.soft_reset_pulse) else $error("Soft reset pulse too long");
  gm_fields_a: assert property (
    acc_w && paddr == 32'h2C && !pwdata[7] |=> gm_bits == $past(pwdata[6:0]))
    else $error("General mode controls differ from write");
  pulse_src_a: assert property (
    acc_w && paddr == 32'h30 |=>
    ctrl.pulse_two_source == ($past(pwdata[7]) ? {1'b1, $past(pwdata[3])} : $past(pwdata[7:6]))
    && ctrl.pulse_one_source == ($past(pwdata[5]) ? {1'b1, $past(pwdata[3])} : $past(pwdata[5:4])))
    else $error("Pulse source decode wrong");
  pm_bits_a: assert property (
    acc_w && paddr == 32'h30 |=> {ctrl.rms_zero_cross_update, ctrl.period_frequency_select} == $past(pwdata[2:1]))
    else $error("Pulse mode flags wrong");
  nl_enable_a: assert property (
    acc_w && paddr == 32'h38 |=> ctrl.current_rms_noload_enable == $past(pwdata[6]))
    else $error("Current no-load enable wrong");
  nl_off_a: assert property (
    acc_w && paddr == 32'h38 |=> ((ctrl.apparent_noload_level == 16'h0) == ($past(pwdata[5:4]) == 2'h0))
    && ((ctrl.reactive_noload_level == 16'h0) == ($past(pwdata[3:2]) == 2'h0))
    && ((ctrl.active_noload_level == 16'h0) == ($past(pwdata[1:0]) == 2'h0))) else $error("No-load disable wrong");
  cfg_hold_a: assert property (
    !acc_w |=> $stable({ctrl.apparent_noload_level, ctrl.reactive_noload_level, ctrl.active_noload_level,
    ctrl.pulse_two_source, ctrl.pulse_one_source})) else $error("Settings changed without write");
  line_read_a: assert property (
    psel && penable && !pwrite && paddr == 32'h28 |-> prdata == {16'h0, $past(ctrl.period_frequency_select) ?
    $past(samples.line_frequency) : $past(samples.line_period)}) else $error("Line measurement read wrong");
  wave_pulse_a: assert property (
    waveform_valid |=> !waveform_valid) else $error("Sample strobe too long");
endmodule
bind energy_meter_config_regs energy_meter_config_props props_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pready(pready), .samples(samples), .ctrl(ctrl), .waveform_valid(waveform_valid));

// File: testbench/meter_datapath_model.sv
// Behavioural metering datapath that feeds fixed samples to the bank
`timescale 1ns/1ps
module meter_datapath_model #(
  parameter meter_cfg_pkg::meter_samples_t VALS = '0
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire meter_cfg_pkg::meter_ctrl_t ctrl, // Controls from bank
  output meter_cfg_pkg::meter_samples_t samples // Samples to bank
);
  // Inverted pattern in reset so stale values never look right
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      samples <= ~VALS;
    end else begin
      samples <= VALS;
    end
  end
endmodule

// File: testbench/tb_energy_meter_config_regs.sv
// Self-checking testbench for the metering configuration bank
`timescale 1ns/1ps
module tb_energy_meter_config_regs;
  localparam meter_cfg_pkg::meter_samples_t VALS = {24'h123456, 24'h2468AC, 24'h3579BD, 24'h4680CE,
    24'h5791DF, 32'h00ABCDEF, 16'h1F40, 16'h0032};
  localparam logic [15:0] APP_T [4] = '{16'h0000, 16'h012C, 16'h0096, 16'h004B};
  localparam logic [15:0] RA_T [4] = '{16'h0000, 16'h0096, 16'h004B, 16'h0025};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [23:0] waveform_one;
  logic [23:0] waveform_two;
  logic waveform_valid;
  meter_cfg_pkg::meter_samples_t samples;
  meter_cfg_pkg::meter_ctrl_t ctrl;
  int errors = 0;
  int num_checks = 0;
  energy_meter_config_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .samples(samples), .ctrl(ctrl), .waveform_one(waveform_one),
    .waveform_two(waveform_two), .waveform_valid(waveform_valid));
  meter_datapath_model #(.VALS(VALS)) model_u (.pclk(pclk), .presetn(presetn), .ctrl(ctrl), .samples(samples));
  initial begin
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] r, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Access phase ends at the rising edge that sees pready high; data taken there
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      finish_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b1, d, 4'hF, r, e);
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    xfer(a, 1'b0, 32'h0, 4'h0, r, e);
    check(r, exp);
  endtask
  task automatic wait_valid(output int n);
    n = 0;
    do begin @(negedge pclk); n++; end while (waveform_valid !== 1'b1 && n < 8000);
    if (n >= 8000) begin
      errors++;
      finish_test();
    end
  endtask
  function automatic logic [23:0] wexp(input logic [2:0] c);
    case (c)
      3'h0: return VALS.current;
      3'h1: return VALS.voltage;
      3'h2: return VALS.active;
      3'h3: return VALS.reactive;
      3'h4: return VALS.apparent;
      3'h5: return VALS.irms_lpf[23:0];
      default: return 24'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_defaults();
    rd_chk(32'h2C, {24'h0, meter_cfg_pkg::GENERAL_MODE_RST});
    rd_chk(32'h30, {24'h0, meter_cfg_pkg::PULSE_OUTPUT_MODE_RST});
    rd_chk(32'h34, {24'h0, meter_cfg_pkg::WAVEFORM_SELECT_RST});
    rd_chk(32'h38, {24'h0, meter_cfg_pkg::NO_LOAD_THRESHOLD_RST});
  endtask
  task automatic t_general();
    for (int b = 0; b < 7; b++) begin
      wr(32'h2C, 32'h1 << b);
      rd_chk(32'h2C, 32'h1 << b);
    end
  endtask
  task automatic t_pulse();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[1:0], ~i[1:0], i[2], i[0], i[1], 1'b1};
      wr(32'h30, {24'h0, d});
      rd_chk(32'h30, {24'h0, d});
      rd_chk(32'h28, {16'h0, i[1] ? VALS.line_frequency : VALS.line_period});
    end
  endtask
  task automatic t_noload();
    logic [7:0] d;
    for (int c = 0; c < 4; c++) begin
      d = {1'b1, c[0], c[1:0], c[1:0], c[1:0]};
      wr(32'h38, {24'h0, d});
      @(negedge pclk);
      check(ctrl.apparent_noload_level, APP_T[c]);
      check(ctrl.reactive_noload_level, RA_T[c]);
      check(ctrl.active_noload_level, RA_T[c]);
      check(ctrl.current_rms_noload_enable, c[0]);
      rd_chk(32'h38, {24'h0, 1'b0, d[6:0]});
    end
  endtask
  task automatic t_refuse();
    logic [31:0] r;
    logic e;
    wr(32'h28, 32'h0000FFFF);
    rd_chk(32'h28, {16'h0, VALS.line_frequency});
    xfer(32'h3C, 1'b0, 32'h0, 4'h0, r, e);
    check(r, 32'h0);
    check({31'h0, e}, 32'h1);
    xfer(32'h2D, 1'b0, 32'h0, 4'h0, r, e);
    check({31'h0, e}, 32'h1);
    xfer(32'h38, 1'b1, 32'h15, 4'h0, r, e);
    rd_chk(32'h38, 32'h7F);
  endtask
  task automatic t_reset();
    for (int k = 0; k < 2; k++) begin
      wr(32'h2C, 32'h79);
      wr(32'h30, 32'hAF);
      wr(32'h34, 32'hFF);
      wr(32'h38, 32'h7F);
      if (k == 0) begin
        wr(32'h2C, 32'hFF);
      end else begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
      end
      t_defaults();
    end
  endtask
  task automatic t_wave();
    int n;
    for (int c = 0; c < 12; c++) begin
      wr(32'h34, c < 4 ? c : {24'h0, c[2:0], c[2:0], 2'h0});
      repeat (3) wait_valid(n);
      if (c < 4) check(n, (meter_cfg_pkg::BASE_DIV * 32) << c);
      else begin
        check(waveform_one, wexp(c[2:0]));
        check(waveform_two, wexp(c[2:0]));
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_general();
    t_pulse();
    t_noload();
    t_refuse();
    t_reset();
    t_wave();
    finish_test();
  end
endmodule
